/* File: hdl/iorsd_params.svh */
// Overview of operation
// - single-bit set and clear change only writable bits at locations 0x00 to 0x1F; set on a write-one-clear flag clears it.
// - skip-if-bit-set and skip-if-bit-clear test one bit in locations 0x00 to 0x1F.
// - some status flags clear on writing one; writing zero leaves them unchanged.
// - single-bit set or clear touches only the addressed bit, no read-modify-write.
// - single-bit set and clear are refused above location 0x1F.
// - port read and port write address locations 0x00 to 0x3F, 64 entries.
// - data-space address of an I/O register is its location plus 0x20.
// - extended region 0x60 to 0xFF is reachable only by data-space read and write.
`ifndef IORSD_PARAMS_SVH
`define IORSD_PARAMS_SVH

`define IORSD_DATA_OFS 16'h0020
`define IORSD_IO_TOP 16'h003F
`define IORSD_BIT_TOP 16'h001F
`define IORSD_DATA_IO_TOP 16'h005F
`define IORSD_EXT_LO 16'h0060
`define IORSD_EXT_HI 16'h00FF
`define IORSD_RESET_VAL 8'h00

`define IORSD_OFS_PORT_B_IN 6'h03
`define IORSD_OFS_PORT_B_DIR 6'h04
`define IORSD_OFS_PORT_B_OUT 6'h05
`define IORSD_OFS_PORT_C_IN 6'h06
`define IORSD_OFS_PORT_C_DIR 6'h07
`define IORSD_OFS_PORT_C_OUT 6'h08
`define IORSD_OFS_PORT_D_IN 6'h09
`define IORSD_OFS_PORT_D_DIR 6'h0A
`define IORSD_OFS_PORT_D_OUT 6'h0B
`define IORSD_OFS_TMR0_FLAGS 6'h15
`define IORSD_OFS_TMR1_FLAGS 6'h16
`define IORSD_OFS_TMR2_FLAGS 6'h17
`define IORSD_OFS_PCHG_FLAGS 6'h1B
`define IORSD_OFS_EXT_FLAGS 6'h1C
`define IORSD_OFS_EXT_MASK 6'h1D
`define IORSD_OFS_SCRATCH0 6'h1E
`define IORSD_OFS_NV_CTRL 6'h1F
`define IORSD_OFS_NV_DATA 6'h20
`define IORSD_OFS_NV_ADDR_LO 6'h21
`define IORSD_OFS_NV_ADDR_HI 6'h22
`define IORSD_OFS_PRESC_CTRL 6'h23
`define IORSD_OFS_TMR0_CTRL_A 6'h24
`define IORSD_OFS_TMR0_CTRL_B 6'h25
`define IORSD_OFS_TMR0_COUNT 6'h26
`define IORSD_OFS_TMR0_CMP_A 6'h27
`define IORSD_OFS_TMR0_CMP_B 6'h28
`define IORSD_OFS_SCRATCH1 6'h2A
`define IORSD_OFS_SCRATCH2 6'h2B
`define IORSD_OFS_SPI_CTRL 6'h2C
`define IORSD_OFS_SPI_STATUS 6'h2D
`define IORSD_OFS_SPI_DATA 6'h2E
`define IORSD_OFS_CMP_CS 6'h30
`define IORSD_OFS_SLEEP_CTRL 6'h33
`define IORSD_OFS_RESET_CAUSE 6'h34

// writable, write-one-clear, write-zero-clear and live-input bit masks
`define IORSD_MASK_FULL 8'hFF
`define IORSD_MASK_PORT_C 8'h7F
`define IORSD_MASK_TMR0_FLAGS 8'h07
`define IORSD_MASK_TMR1_FLAGS 8'h27
`define IORSD_MASK_TMR2_FLAGS 8'h07
`define IORSD_MASK_PCHG_FLAGS 8'h07
`define IORSD_MASK_EXT_BITS 8'h03
`define IORSD_MASK_NV_CTRL 8'h3F
`define IORSD_MASK_PRESC_CTRL 8'h83
`define IORSD_MASK_TMR0_CTRL_A 8'hF3
`define IORSD_MASK_TMR0_CTRL_B 8'h0F
`define IORSD_MASK_SPI_STAT_WR 8'h01
`define IORSD_MASK_SPI_STAT_FL 8'hC0
`define IORSD_MASK_CMP_WR 8'hCF
`define IORSD_MASK_CMP_FLAG 8'h10
`define IORSD_MASK_CMP_LIVE 8'h20
`define IORSD_POS_CMP_LIVE 5
`define IORSD_MASK_SLEEP 8'h0F
`define IORSD_MASK_RESET_CAUSE 8'h0F

`endif

/* File: hdl/iorsd_pkg.sv */
package iorsd_pkg;

  typedef enum logic [2:0] {
    IORSD_OP_PORT_RD = 3'h0,
    IORSD_OP_PORT_WR = 3'h1,
    IORSD_OP_BIT_SET = 3'h2,
    IORSD_OP_BIT_CLR = 3'h3,
    IORSD_OP_SKIP_SET = 3'h4,
    IORSD_OP_SKIP_CLR = 3'h5,
    IORSD_OP_MEM_RD = 3'h6,
    IORSD_OP_MEM_WR = 3'h7
  } iorsd_op_t;

  typedef logic [5:0] iorsd_loc_t;
  typedef logic [7:0] iorsd_byte_t;

endpackage

/* File: hdl/iorsd_dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface iorsd_dec_if
  import iorsd_pkg::*;
#(
  parameter int ADDR_W = 16
);
  iorsd_op_t op;
  logic [ADDR_W-1:0] addr;
  logic hit_io;
  logic hit_ext;
  logic refused;
  iorsd_loc_t loc;

  modport decoder (input op, input addr, output hit_io, output hit_ext, output refused,
    output loc);
  modport user (output op, output addr, input hit_io, input hit_ext, input refused,
    input loc);
endinterface
`default_nettype wire

/* File: hdl/iorsd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iorsd_params.svh"
module iorsd_decode
  import iorsd_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  iorsd_dec_if.decoder dec
);

  logic [15:0] addr16;
  logic [15:0] data_loc;

  assign addr16 = 16'(dec.addr);
  assign data_loc = addr16 - `IORSD_DATA_OFS;

  always_comb
  begin
    dec.hit_io = 1'b0;
    dec.hit_ext = 1'b0;
    dec.refused = 1'b0;
    dec.loc = addr16[5:0];
    case (dec.op)
      IORSD_OP_PORT_RD, IORSD_OP_PORT_WR:
      begin
        dec.hit_io = (addr16 <= `IORSD_IO_TOP);
        dec.refused = !dec.hit_io;
      end
      IORSD_OP_BIT_SET, IORSD_OP_BIT_CLR, IORSD_OP_SKIP_SET, IORSD_OP_SKIP_CLR:
      begin
        dec.hit_io = (addr16 <= `IORSD_BIT_TOP);
        dec.refused = !dec.hit_io;
      end
      IORSD_OP_MEM_RD, IORSD_OP_MEM_WR:
      begin
        if (addr16 >= `IORSD_DATA_OFS && addr16 <= `IORSD_DATA_IO_TOP)
        begin
          dec.hit_io = 1'b1;
          dec.loc = data_loc[5:0];
        end
        else if (addr16 >= `IORSD_EXT_LO && addr16 <= `IORSD_EXT_HI)
        begin
          dec.hit_ext = 1'b1;
        end
        else
        begin
          dec.refused = 1'b1;
        end
      end
      default:
      begin
        dec.refused = 1'b1;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: hdl/iorsd_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iorsd_params.svh"
module iorsd_top
  import iorsd_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int LOCS = 64
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire iorsd_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [2:0] req_bit,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_d,
  input wire logic cmp_level,
  input wire logic [7:0] tmr0_flag_set,
  input wire logic [7:0] tmr1_flag_set,
  input wire logic [7:0] tmr2_flag_set,
  input wire logic [7:0] pchg_flag_set,
  input wire logic [7:0] ext_flag_set,
  input wire logic [7:0] spi_flag_set,
  input wire logic [7:0] cmp_flag_set,
  input wire logic [7:0] reset_cause_set,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_skip,
  output logic rsp_refused,
  output logic [LOCS*8-1:0] reg_image
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  iorsd_dec_if #(.ADDR_W(ADDR_W)) dec ();

  assign dec.op = req_op;
  assign dec.addr = req_addr;

  iorsd_decode #(.ADDR_W(ADDR_W)) u_decode (
    .dec(dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-location bit behaviour

  // bits that a byte write or a set/clear stores
  function automatic iorsd_byte_t wr_mask(input iorsd_loc_t loc);
    case (loc)
      `IORSD_OFS_PORT_B_DIR, `IORSD_OFS_PORT_B_OUT: wr_mask = `IORSD_MASK_FULL;
      `IORSD_OFS_PORT_C_DIR, `IORSD_OFS_PORT_C_OUT: wr_mask = `IORSD_MASK_PORT_C;
      `IORSD_OFS_PORT_D_DIR, `IORSD_OFS_PORT_D_OUT: wr_mask = `IORSD_MASK_FULL;
      `IORSD_OFS_EXT_MASK: wr_mask = `IORSD_MASK_EXT_BITS;
      `IORSD_OFS_SCRATCH0, `IORSD_OFS_SCRATCH1, `IORSD_OFS_SCRATCH2:
        wr_mask = `IORSD_MASK_FULL;
      `IORSD_OFS_NV_CTRL: wr_mask = `IORSD_MASK_NV_CTRL;
      `IORSD_OFS_NV_DATA, `IORSD_OFS_NV_ADDR_LO, `IORSD_OFS_NV_ADDR_HI:
        wr_mask = `IORSD_MASK_FULL;
      `IORSD_OFS_PRESC_CTRL: wr_mask = `IORSD_MASK_PRESC_CTRL;
      `IORSD_OFS_TMR0_CTRL_A: wr_mask = `IORSD_MASK_TMR0_CTRL_A;
      `IORSD_OFS_TMR0_CTRL_B: wr_mask = `IORSD_MASK_TMR0_CTRL_B;
      `IORSD_OFS_TMR0_COUNT, `IORSD_OFS_TMR0_CMP_A, `IORSD_OFS_TMR0_CMP_B:
        wr_mask = `IORSD_MASK_FULL;
      `IORSD_OFS_SPI_CTRL, `IORSD_OFS_SPI_DATA: wr_mask = `IORSD_MASK_FULL;
      `IORSD_OFS_SPI_STATUS: wr_mask = `IORSD_MASK_SPI_STAT_WR;
      `IORSD_OFS_CMP_CS: wr_mask = `IORSD_MASK_CMP_WR;
      `IORSD_OFS_SLEEP_CTRL: wr_mask = `IORSD_MASK_SLEEP;
      default: wr_mask = 8'h00;
    endcase
  endfunction

  // status flags that hardware sets and a written one clears
  function automatic iorsd_byte_t w1c_mask(input iorsd_loc_t loc);
    case (loc)
      `IORSD_OFS_TMR0_FLAGS: w1c_mask = `IORSD_MASK_TMR0_FLAGS;
      `IORSD_OFS_TMR1_FLAGS: w1c_mask = `IORSD_MASK_TMR1_FLAGS;
      `IORSD_OFS_TMR2_FLAGS: w1c_mask = `IORSD_MASK_TMR2_FLAGS;
      `IORSD_OFS_PCHG_FLAGS: w1c_mask = `IORSD_MASK_PCHG_FLAGS;
      `IORSD_OFS_EXT_FLAGS: w1c_mask = `IORSD_MASK_EXT_BITS;
      `IORSD_OFS_SPI_STATUS: w1c_mask = `IORSD_MASK_SPI_STAT_FL;
      `IORSD_OFS_CMP_CS: w1c_mask = `IORSD_MASK_CMP_FLAG;
      default: w1c_mask = 8'h00;
    endcase
  endfunction

  // reset-cause flags: set by hardware, cleared by writing zero
  function automatic iorsd_byte_t w0c_mask(input iorsd_loc_t loc);
    case (loc)
      `IORSD_OFS_RESET_CAUSE: w0c_mask = `IORSD_MASK_RESET_CAUSE;
      default: w0c_mask = 8'h00;
    endcase
  endfunction

  // bits that mirror an input level
  function automatic iorsd_byte_t live_mask(input iorsd_loc_t loc);
    case (loc)
      `IORSD_OFS_PORT_B_IN, `IORSD_OFS_PORT_D_IN: live_mask = `IORSD_MASK_FULL;
      `IORSD_OFS_PORT_C_IN: live_mask = `IORSD_MASK_PORT_C;
      `IORSD_OFS_CMP_CS: live_mask = `IORSD_MASK_CMP_LIVE;
      default: live_mask = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // access qualification

  logic acc_io;
  logic byte_wr;
  logic bit_set;
  logic bit_clr;
  iorsd_byte_t bit_sel;

  assign acc_io = req_valid && dec.hit_io;
  assign byte_wr = acc_io && (req_op == IORSD_OP_PORT_WR || req_op == IORSD_OP_MEM_WR);
  assign bit_set = acc_io && (req_op == IORSD_OP_BIT_SET);
  assign bit_clr = acc_io && (req_op == IORSD_OP_BIT_CLR);
  assign bit_sel = 8'h01 << req_bit;

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  iorsd_byte_t io_r [LOCS];

  genvar gi;
  generate
    for (gi = 0; gi < LOCS; gi++)
    begin : g_loc
      localparam iorsd_loc_t LOC = iorsd_loc_t'(gi);
      localparam iorsd_byte_t WM = wr_mask(LOC);
      localparam iorsd_byte_t CM = w1c_mask(LOC);
      localparam iorsd_byte_t ZM = w0c_mask(LOC);
      localparam iorsd_byte_t LM = live_mask(LOC);

      logic sel;
      iorsd_byte_t hw_set;
      iorsd_byte_t live_in;
      iorsd_byte_t loc_nxt;

      assign sel = (dec.loc == LOC);

      always_comb
      begin
        hw_set = 8'h00;
        live_in = 8'h00;
        case (LOC)
          `IORSD_OFS_PORT_B_IN: live_in = pin_b;
          `IORSD_OFS_PORT_C_IN: live_in = pin_c;
          `IORSD_OFS_PORT_D_IN: live_in = pin_d;
          `IORSD_OFS_CMP_CS:
          begin
            live_in[`IORSD_POS_CMP_LIVE] = cmp_level;
            hw_set = cmp_flag_set;
          end
          `IORSD_OFS_TMR0_FLAGS: hw_set = tmr0_flag_set;
          `IORSD_OFS_TMR1_FLAGS: hw_set = tmr1_flag_set;
          `IORSD_OFS_TMR2_FLAGS: hw_set = tmr2_flag_set;
          `IORSD_OFS_PCHG_FLAGS: hw_set = pchg_flag_set;
          `IORSD_OFS_EXT_FLAGS: hw_set = ext_flag_set;
          `IORSD_OFS_SPI_STATUS: hw_set = spi_flag_set;
          `IORSD_OFS_RESET_CAUSE: hw_set = reset_cause_set;
          default: hw_set = 8'h00;
        endcase
      end

      always_comb
      begin
        loc_nxt = io_r[gi];
        if (sel && byte_wr)
        begin
          loc_nxt = (loc_nxt & ~WM) | (req_wdata & WM);
          loc_nxt = loc_nxt & ~(req_wdata & CM);
          loc_nxt = loc_nxt & (req_wdata | ~ZM);
        end
        else if (sel && bit_set)
        begin
          loc_nxt = loc_nxt | (bit_sel & WM);
          loc_nxt = loc_nxt & ~(bit_sel & CM);
        end
        else if (sel && bit_clr)
        begin
          loc_nxt = loc_nxt & ~(bit_sel & (WM | ZM));
        end
        loc_nxt = loc_nxt | (hw_set & (CM | ZM));
        loc_nxt = (loc_nxt & ~LM) | (live_in & LM);
      end

      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          io_r[gi] <= `IORSD_RESET_VAL;
        end
        else
        begin
          io_r[gi] <= loc_nxt;
        end
      end

      assign reg_image[gi*8 +: 8] = io_r[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read and answer

  iorsd_byte_t rd_val;
  logic rd_bit;

  // extended region holds nothing here and reads zero
  assign rd_val = dec.hit_io ? io_r[dec.loc] : 8'h00;
  assign rd_bit = rd_val[req_bit];

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_valid <= 1'b0;
      rsp_refused <= 1'b0;
    end
    else
    begin
      rsp_valid <= req_valid;
      rsp_refused <= req_valid && dec.refused;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_rdata <= 8'h00;
    end
    else if (req_valid)
    begin
      case (req_op)
        IORSD_OP_PORT_RD, IORSD_OP_MEM_RD: rsp_rdata <= rd_val;
        default: rsp_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_skip <= 1'b0;
    end
    else if (req_valid)
    begin
      case (req_op)
        IORSD_OP_SKIP_SET: rsp_skip <= dec.hit_io && rd_bit;
        IORSD_OP_SKIP_CLR: rsp_skip <= dec.hit_io && !rd_bit;
        default: rsp_skip <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: tb/iorsd_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module iorsd_top_sva
  import iorsd_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int LOCS = 64
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire iorsd_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [2:0] req_bit,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] tmr0_flag_set,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  input wire logic rsp_skip,
  input wire logic rsp_refused,
  input wire logic [LOCS*8-1:0] reg_image
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  wire logic [7:0] scratch_val = reg_image[247:240];
  wire logic [7:0] flag_val = reg_image[175:168];
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take(iorsd_op_t op, logic [15:0] a);
    req_valid && req_op == op && req_addr == a;
  endsequence
  property p_bit_refuse;
    req_valid && (req_op == IORSD_OP_BIT_SET || req_op == IORSD_OP_BIT_CLR)
      && req_addr > 16'h001F |=> rsp_valid && rsp_refused;
  endproperty
  a_bit_refuse: assert property (p_bit_refuse)
    else $error("bit op above 0x1F not refused");
  property p_port_refuse;
    req_valid && (req_op == IORSD_OP_PORT_RD || req_op == IORSD_OP_PORT_WR)
      && req_addr > 16'h003F |=> rsp_refused;
  endproperty
  a_port_refuse: assert property (p_port_refuse)
    else $error("port op above 0x3F not refused");
  property p_mem_offset;
    s_take(IORSD_OP_MEM_WR, 16'h003E) |=> scratch_val == $past(req_wdata);
  endproperty
  a_mem_offset: assert property (p_mem_offset)
    else $error("data address 0x3E did not reach location 0x1E");
  property p_bit_set;
    s_take(IORSD_OP_BIT_SET, 16'h001E)
      |=> scratch_val == ($past(scratch_val) | (8'h01 << $past(req_bit)));
  endproperty
  a_bit_set: assert property (p_bit_set)
    else $error("bit set changed more than one bit");
  property p_bit_clear;
    s_take(IORSD_OP_BIT_CLR, 16'h001E)
      |=> scratch_val == ($past(scratch_val) & ~(8'h01 << $past(req_bit)));
  endproperty
  a_bit_clear: assert property (p_bit_clear)
    else $error("bit clear changed more than one bit");
  property p_skip;
    s_take(IORSD_OP_SKIP_SET, 16'h001E) ##1 rsp_valid
      |-> (($past(scratch_val) >> $past(req_bit)) & 8'h01) == {7'h00, rsp_skip};
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip outcome differs from tested bit");
  property p_w1c;
    s_take(IORSD_OP_PORT_WR, 16'h0015) ##0 tmr0_flag_set == 8'h00
      |=> flag_val == ($past(flag_val) & ~$past(req_wdata));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag write did not clear ones only");
  property p_unassigned;
    s_take(IORSD_OP_PORT_RD, 16'h0002) |=> rsp_valid && !rsp_refused && rsp_rdata == 8'h00;
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("unassigned location did not read zero");
  property p_ext;
    req_valid && req_op == IORSD_OP_MEM_RD && req_addr >= 16'h0060 && req_addr <= 16'h00FF
      |=> rsp_valid && !rsp_refused;
  endproperty
  a_ext: assert property (p_ext)
    else $error("extended region read refused");
endmodule
`default_nettype wire

/* File: tb/iorsd_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iorsd_core_model
  import iorsd_pkg::*;
(
  input wire logic clock,
  output logic req_valid,
  output iorsd_op_t req_op,
  output logic [15:0] req_addr,
  output logic [2:0] req_bit,
  output logic [7:0] req_wdata
);
  initial
  begin
    req_valid = 1'b0;
    req_op = IORSD_OP_PORT_RD;
    req_addr = 16'h0000;
    req_bit = 3'h0;
    req_wdata = 8'h00;
  end
  // callers also write read-only and extended places, with random data
  task automatic issue(input iorsd_op_t op, input logic [15:0] a, input logic [2:0] b,
    input logic [7:0] d);
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_bit <= b;
    req_wdata <= d;
  endtask
  // released request carries no stale address or data
  task automatic idle();
    @(posedge clock);
    req_valid <= 1'b0;
    req_addr <= ~req_addr;
    req_wdata <= ~req_wdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/io_register_space_decoder_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iorsd_params.svh"
module io_register_space_decoder_test
  import iorsd_pkg::*;
;
  typedef struct packed {logic [7:0] d; logic s; logic r;} iorsd_note_t;
  localparam int FL [8] = '{8'h15, 8'h16, 8'h17, 8'h1B, 8'h1C, 8'h2D, 8'h30, 8'h34};
  localparam logic [7:0] FM [8] = '{`IORSD_MASK_TMR0_FLAGS, `IORSD_MASK_TMR1_FLAGS,
    `IORSD_MASK_TMR2_FLAGS, `IORSD_MASK_PCHG_FLAGS, `IORSD_MASK_EXT_BITS,
    `IORSD_MASK_SPI_STAT_FL, `IORSD_MASK_CMP_FLAG, `IORSD_MASK_RESET_CAUSE};
  logic clock, rst_b, cmp_level, req_valid, rsp_valid, rsp_skip, rsp_refused;
  logic [7:0] pin_b, pin_c, pin_d, req_wdata, rsp_rdata, sc, v;
  logic [7:0] fs [8];
  iorsd_op_t req_op;
  logic [15:0] req_addr;
  logic [2:0] req_bit;
  logic [511:0] reg_image;
  logic [31:0] seed;
  iorsd_note_t notes [$];
  iorsd_note_t n;
  int mismatches, comparisons, cycles;
  iorsd_core_model core (.clock(clock), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata));
  iorsd_top dut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata), .pin_b(pin_b),
    .pin_c(pin_c), .pin_d(pin_d), .cmp_level(cmp_level), .tmr0_flag_set(fs[0]),
    .tmr1_flag_set(fs[1]), .tmr2_flag_set(fs[2]), .pchg_flag_set(fs[3]),
    .ext_flag_set(fs[4]), .spi_flag_set(fs[5]), .cmp_flag_set(fs[6]),
    .reset_cause_set(fs[7]), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_skip(rsp_skip), .rsp_refused(rsp_refused), .reg_image(reg_image));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input iorsd_op_t op, input logic [15:0] a, input logic [2:0] b,
    input logic [7:0] d, input logic [7:0] xd, input logic xs, input logic xr);
    notes.push_back('{xd, xs, xr});
    core.issue(op, a, b, d);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  // oldest note against each answer
  always @(posedge clock)
    if (rsp_valid === 1'b1)
    begin
      n = notes.size() > 0 ? notes.pop_front() : '1;
      check(rsp_rdata, n.d);
      check({7'h00, rsp_skip}, {7'h00, n.s});
      check({7'h00, rsp_refused}, {7'h00, n.r});
    end
  initial
  begin
    rst_b = 1'b0;
    cmp_level = 1'b0;
    fs = '{default: 8'h00};
    seed = 32'h000137E2;
    pin_b = rnd();
    pin_c = rnd();
    pin_d = rnd();
    repeat (9) @(posedge clock);
    for (int i = 0; i < 64; i++) check(reg_image[i*8+:8], 8'h00); // reset values
    @(posedge clock);
    rst_b <= 1'b1;
    sc = rnd();
    v = rnd();
    acc(IORSD_OP_PORT_WR, 16'h001E, 3'h0, sc, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_RD, 16'h001E, 3'h0, 8'h00, sc, 1'b0, 1'b0);
    acc(IORSD_OP_MEM_RD, 16'h003E, 3'h0, 8'h00, sc, 1'b0, 1'b0);
    acc(IORSD_OP_MEM_WR, 16'h003E, 3'h0, v, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_RD, 16'h001E, 3'h0, 8'h00, v, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_WR, 16'h0003, 3'h0, v, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_RD, 16'h0003, 3'h0, 8'h00, pin_b, 1'b0, 1'b0); // read-only pins
    acc(IORSD_OP_MEM_RD, 16'h0026, 3'h0, 8'h00, pin_c & 8'h7F, 1'b0, 1'b0);
    sc = v;
    for (int i = 0; i < 8; i++)
    begin
      acc(IORSD_OP_SKIP_SET, 16'h001E, i[2:0], 8'h00, 8'h00, sc[i], 1'b0);
      acc(sc[i] ? IORSD_OP_BIT_CLR : IORSD_OP_BIT_SET, 16'h001E, i[2:0], 8'h00, 8'h00,
        1'b0, 1'b0);
      sc[i] = ~sc[i];
      acc(IORSD_OP_SKIP_CLR, 16'h001E, i[2:0], 8'h00, 8'h00, ~sc[i], 1'b0);
      acc(IORSD_OP_PORT_RD, 16'h001E, 3'h0, 8'h00, sc, 1'b0, 1'b0);
    end
    core.idle();
    fs <= '{default: 8'hFF};
    @(posedge clock);
    fs <= '{default: 8'h00};
    repeat (3) @(posedge clock);
    for (int i = 0; i < 8; i++) check(reg_image[FL[i]*8+:8], FM[i]);
    cmp_level <= 1'b1;
    acc(IORSD_OP_BIT_SET, 16'h0015, 3'h1, 8'h00, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_RD, 16'h0015, 3'h0, 8'h00, 8'h05, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_WR, 16'h0015, 3'h0, 8'h04, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_WR, 16'h0015, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_MEM_RD, 16'h0035, 3'h0, 8'h00, 8'h01, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_WR, 16'h0034, 3'h0, 8'h0A, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_RD, 16'h0034, 3'h0, 8'h00, 8'h0A, 1'b0, 1'b0); // write-zero clear
    acc(IORSD_OP_BIT_SET, 16'h0020, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1);
    acc(IORSD_OP_MEM_RD, 16'h0040, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_RD, 16'h0040, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1);
    acc(IORSD_OP_MEM_RD, 16'h001F, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1);
    acc(IORSD_OP_MEM_WR, 16'h0060, 3'h0, rnd(), 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_MEM_RD, 16'h0060, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_MEM_RD, 16'h00FF, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_RD, 16'h0002, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0);
    acc(IORSD_OP_MEM_RD, 16'h0050, 3'h0, 8'h00, 8'h30, 1'b0, 1'b0);
    acc(IORSD_OP_PORT_RD, 16'h0009, 3'h0, 8'h00, pin_d, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      v = rnd();
      acc(IORSD_OP_MEM_WR, 16'h004B, 3'h0, v, 8'h00, 1'b0, 1'b0);
      acc(IORSD_OP_PORT_RD, 16'h002B, 3'h0, 8'h00, v, 1'b0, 1'b0);
    end
    core.idle();
    repeat (4) @(posedge clock);
    check(8'(notes.size()), 8'h00); // every answer arrived
    print_verdict();
  end
endmodule
bind iorsd_top iorsd_top_sva #(.ADDR_W(ADDR_W), .LOCS(LOCS)) u_sva (.clock(clock),
  .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
  .req_bit(req_bit), .req_wdata(req_wdata), .tmr0_flag_set(tmr0_flag_set),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip),
  .rsp_refused(rsp_refused), .reg_image(reg_image));
`default_nettype wire
